// file: hw/harvard_risc_core_datapath.sv
// execution datapath of the 8-bit harvard core: fetch, decode, alu, flags
// Functional notes
// - fetch one 12-bit instruction per cycle
// - fetch of next overlaps current execute
// - single cycle except branches, which refill
// - separate program and data buses
// - pc reaches 512, 1K or 2K words
// - special registers, pc included, in data map
// - 8-bit alu: add, subtract, shift, logic
// - arithmetic is two's complement
// - operands: accumulator with file or literal
// - accumulator feeds alu, has no address
// - alu updates carry, nibble carry, zero
// - subtract: carries are inverted borrows
// - rc mode: rate output at quarter frequency
// - master reset active low, holds device
`timescale 1ns/1ps
`include "core_cfg.svh"
module harvard_risc_core_datapath #(
  parameter int PC_WIDTH = `PC_WIDTH_DEFAULT // 9, 10 or 11 for the variants
) (
  input wire logic clock_i, // oscillator, the crystal_input_pin
  input wire logic sys_rst_i,
  input wire logic master_reset_n_i, // pin, active low
  input wire logic rc_mode_i, // oscillator mode strap, pin
  output logic [PC_WIDTH-1:0] prog_addr_o,
  input wire logic [`INSTR_WIDTH-1:0] prog_data_i,
  output logic [`DADDR_WIDTH-1:0] data_addr_o,
  output logic [`DATA_WIDTH-1:0] data_wdata_o,
  output logic data_we_o,
  input wire logic [`DATA_WIDTH-1:0] data_rdata_i,
  output logic instruction_rate_output_o,
  output logic [`DATA_WIDTH-1:0] acc_o,
  output logic [`DATA_WIDTH-1:0] status_o
);
  // pin synchronisers: first stage feeds only the second
  logic [1:0] mrst_sync_q;
  logic [1:0] rc_sync_q;
  logic hold; // core held in reset

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mrst_sync_q <= 2'h0;
      rc_sync_q <= 2'h0;
    end else begin
      mrst_sync_q <= {mrst_sync_q[0], master_reset_n_i};
      rc_sync_q <= {rc_sync_q[0], rc_mode_i};
    end
  end
  assign hold = !mrst_sync_q[1];

  // phase generation
  core_pkg::phase_type phase;
  logic cycle_end; // last phase of an instruction cycle

  quarter_phase_gen u_phase (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .hold_i(hold),
    .rc_mode_i(rc_sync_q[1]),
    .phase_o(phase),
    .cycle_end_o(cycle_end),
    .rate_clk_o(instruction_rate_output_o)
  );

  // architectural state
  logic [PC_WIDTH-1:0] pc_q, pc_d; // fetch address
  logic [`INSTR_WIDTH-1:0] ir_q, ir_d; // executing instruction
  logic [`DATA_WIDTH-1:0] w_q, w_d; // accumulator, not in the file map
  logic [`DATA_WIDTH-1:0] status_q, status_d;
  logic [`DATA_WIDTH-1:0] fsr_q, fsr_d; // indirect pointer
  logic [PC_WIDTH-1:0] stk0_q, stk0_d, stk1_q, stk1_d; // two-level return stack
  logic [`DADDR_WIDTH-1:0] daddr_q, daddr_d;
  logic [`DATA_WIDTH-1:0] dwdata_q, dwdata_d;
  logic dwe_q, dwe_d;

  // maps an effective file address onto the core's own registers
  function automatic logic [2:0] sfr_decode(input logic [`DADDR_WIDTH-1:0] ea);
    logic [2:0] sel;
    sel = `SFR_NONE;
    if (ea[4:0] == `ADDR_INDIRECT) begin
      sel = `SFR_INDIRECT;
    end else if (ea[4:0] == `ADDR_PCL) begin
      sel = `SFR_PCL;
    end else if (ea[4:0] == `ADDR_STATUS) begin
      sel = `SFR_STATUS;
    end else if (ea[4:0] == `ADDR_FSR) begin
      sel = `SFR_FSR;
    end
    return sel;
  endfunction

  // instruction fields
  logic [4:0] f_field;
  logic dest_f; // result goes to the file register
  logic [7:0] lit;
  logic [`DADDR_WIDTH-1:0] ea; // effective data address
  logic [2:0] sfr_sel;

  assign f_field = ir_q[4:0];
  assign dest_f = ir_q[5];
  assign lit = ir_q[7:0];

  // upper file addresses are banked by the pointer; address 0 goes indirect
  always_comb begin
    if (f_field == `ADDR_INDIRECT) begin
      ea = fsr_q[`DADDR_WIDTH-1:0];
    end else if (f_field[4]) begin
      ea = {fsr_q[6:5], f_field};
    end else begin
      ea = {2'h0, f_field};
    end
    sfr_sel = sfr_decode(ea);
  end

  // decoder outputs
  core_pkg::alu_op_type alu_op;
  logic use_lit, wr_w, wr_f, aff_z, aff_c, aff_dc;
  logic skip_z, test_clr, test_set, is_goto, is_call, is_ret;

  // decode of the executing word
  always_comb begin
    alu_op = core_pkg::ALU_PASS_F;
    use_lit = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    aff_z = 1'b0;
    aff_c = 1'b0;
    aff_dc = 1'b0;
    skip_z = 1'b0;
    test_clr = 1'b0;
    test_set = 1'b0;
    is_goto = 1'b0;
    is_call = 1'b0;
    is_ret = 1'b0;
    case (ir_q[11:8])
      4'h0, 4'h1, 4'h2, 4'h3: begin
        // byte operations between accumulator and file register
        wr_w = !dest_f;
        wr_f = dest_f;
        aff_z = 1'b1;
        case (ir_q[9:6])
          4'h0: begin
            alu_op = core_pkg::ALU_PASS_W; // store accumulator, or no-op
            wr_w = 1'b0;
            aff_z = 1'b0;
          end
          4'h1: alu_op = core_pkg::ALU_CLR;
          4'h2: begin
            alu_op = core_pkg::ALU_SUB; // subtract_acc_from_file
            aff_c = 1'b1;
            aff_dc = 1'b1;
          end
          4'h3: alu_op = core_pkg::ALU_DEC;
          4'h4: alu_op = core_pkg::ALU_IOR;
          4'h5: alu_op = core_pkg::ALU_AND;
          4'h6: alu_op = core_pkg::ALU_XOR;
          4'h7: begin
            alu_op = core_pkg::ALU_ADD; // add_acc_to_file
            aff_c = 1'b1;
            aff_dc = 1'b1;
          end
          4'h8: alu_op = core_pkg::ALU_PASS_F;
          4'h9: alu_op = core_pkg::ALU_COM;
          4'ha: alu_op = core_pkg::ALU_INC;
          4'hb: begin
            alu_op = core_pkg::ALU_DEC;
            aff_z = 1'b0;
            skip_z = 1'b1;
          end
          4'hc: begin
            alu_op = core_pkg::ALU_RRF;
            aff_z = 1'b0;
            aff_c = 1'b1;
          end
          4'hd: begin
            alu_op = core_pkg::ALU_RLF;
            aff_z = 1'b0;
            aff_c = 1'b1;
          end
          4'he: begin
            alu_op = core_pkg::ALU_SWAP;
            aff_z = 1'b0;
          end
          default: begin
            alu_op = core_pkg::ALU_INC;
            aff_z = 1'b0;
            skip_z = 1'b1;
          end
        endcase
        // store form of the first group writes the file, clear of w is allowed
        if (ir_q[9:6] == 4'h0) begin
          wr_f = dest_f;
        end
      end
      4'h4: begin
        alu_op = core_pkg::ALU_BCF;
        wr_f = 1'b1;
      end
      4'h5: begin
        alu_op = core_pkg::ALU_BSF;
        wr_f = 1'b1;
      end
      4'h6: test_clr = 1'b1;
      4'h7: test_set = 1'b1;
      4'h8: begin
        is_ret = 1'b1; // literal return loads the accumulator
        use_lit = 1'b1;
        wr_w = 1'b1;
      end
      4'h9: is_call = 1'b1;
      4'ha, 4'hb: is_goto = 1'b1;
      default: begin
        // literal ops: move, or, and, xor with the accumulator
        use_lit = 1'b1;
        wr_w = 1'b1;
        aff_z = (ir_q[9:8] != 2'h0);
        if (ir_q[9:8] == 2'h1) begin
          alu_op = core_pkg::ALU_IOR;
        end else if (ir_q[9:8] == 2'h2) begin
          alu_op = core_pkg::ALU_AND;
        end else if (ir_q[9:8] == 2'h3) begin
          alu_op = core_pkg::ALU_XOR;
        end
      end
    endcase
  end

  // file operand read; core registers answer locally, the rest over the data bus
  logic [`DATA_WIDTH-1:0] f_val;

  always_comb begin
    if (use_lit) begin
      f_val = lit;
    end else if (sfr_sel == `SFR_INDIRECT) begin
      f_val = 8'h00; // indirect through itself reads zero
    end else if (sfr_sel == `SFR_PCL) begin
      f_val = pc_q[7:0];
    end else if (sfr_sel == `SFR_STATUS) begin
      f_val = status_q;
    end else if (sfr_sel == `SFR_FSR) begin
      f_val = fsr_q;
    end else begin
      f_val = data_rdata_i;
    end
  end

  logic [`DATA_WIDTH-1:0] alu_res;
  logic alu_c, alu_dc, alu_z;

  alu_unit u_alu (
    .op_i(alu_op),
    .f_i(f_val),
    .w_i(w_q),
    .bit_i(ir_q[7:5]),
    .carry_i(status_q[`STATUS_C_BIT]),
    .result_o(alu_res),
    .carry_o(alu_c),
    .nibble_carry_o(alu_dc),
    .zero_o(alu_z)
  );

  // branch target pieces; page bits come from status
  logic [`PC_MAX_WIDTH-1:0] goto_tgt, call_tgt, pcl_tgt;
  logic bit_val, skip, pcl_wr, flush;

  assign goto_tgt = {status_q[`STATUS_PA_HI_BIT:`STATUS_PA_LO_BIT], ir_q[8:0]};
  assign call_tgt = {status_q[`STATUS_PA_HI_BIT:`STATUS_PA_LO_BIT], 1'b0, lit};
  assign pcl_tgt = {status_q[`STATUS_PA_HI_BIT:`STATUS_PA_LO_BIT], 1'b0, alu_res};
  assign bit_val = f_val[ir_q[7:5]];
  assign skip = (skip_z && alu_z) || (test_clr && !bit_val) || (test_set && bit_val);
  assign pcl_wr = wr_f && (sfr_sel == `SFR_PCL);
  // any change of flow discards the word already fetched
  assign flush = is_goto || is_call || is_ret || skip || pcl_wr;

  // next state: all but the data read address and the write strobe commits on the last phase of the cycle
  always_comb begin
    pc_d = pc_q;
    ir_d = ir_q;
    w_d = w_q;
    status_d = status_q;
    fsr_d = fsr_q;
    stk0_d = stk0_q;
    stk1_d = stk1_q;
    dwe_d = 1'b0;
    dwdata_d = dwdata_q;
    daddr_d = ea; // read address for the executing word
    if (hold) begin
      pc_d = '1;
      ir_d = `NOP_WORD;
      w_d = `W_RESET;
      status_d = `STATUS_RESET;
      fsr_d = `FSR_RESET;
      daddr_d = '0;
    end else if (cycle_end) begin
      pc_d = pc_q + PC_WIDTH'(1);
      ir_d = flush ? `NOP_WORD : prog_data_i;
      if (is_goto) begin
        pc_d = goto_tgt[PC_WIDTH-1:0];
      end else if (is_call) begin
        pc_d = call_tgt[PC_WIDTH-1:0];
        stk0_d = pc_q;
        stk1_d = stk0_q;
      end else if (is_ret) begin
        pc_d = stk0_q;
        stk0_d = stk1_q;
      end else if (pcl_wr) begin
        pc_d = pcl_tgt[PC_WIDTH-1:0];
      end
      if (wr_w) begin
        w_d = alu_res;
      end
      if (wr_f && sfr_sel == `SFR_STATUS) begin
        status_d = (status_q & ~`STATUS_WR_MASK) | (alu_res & `STATUS_WR_MASK);
      end else if (wr_f && sfr_sel == `SFR_FSR) begin
        fsr_d = alu_res;
      end else if (wr_f && sfr_sel == `SFR_NONE) begin
        dwe_d = 1'b1; // write lands one clock later, before the next read
        dwdata_d = alu_res;
      end
      // flag updates win over a direct write to status
      if (aff_z) begin
        status_d[`STATUS_Z_BIT] = alu_z;
      end
      if (aff_c) begin
        status_d[`STATUS_C_BIT] = alu_c;
      end
      if (aff_dc) begin
        status_d[`STATUS_DC_BIT] = alu_dc;
      end
    end
  end

  // registers only
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_q <= '1;
      ir_q <= `NOP_WORD;
      w_q <= `W_RESET;
      status_q <= `STATUS_RESET;
      fsr_q <= `FSR_RESET;
      stk0_q <= '0;
      stk1_q <= '0;
      daddr_q <= '0;
      dwdata_q <= '0;
      dwe_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      ir_q <= ir_d;
      w_q <= w_d;
      status_q <= status_d;
      fsr_q <= fsr_d;
      stk0_q <= stk0_d;
      stk1_q <= stk1_d;
      daddr_q <= daddr_d;
      dwdata_q <= dwdata_d;
      dwe_q <= dwe_d;
    end
  end

  // program bus runs independently of the data bus
  assign prog_addr_o = pc_q;
  assign data_addr_o = daddr_q;
  assign data_wdata_o = dwdata_q;
  assign data_we_o = dwe_q;
  assign acc_o = w_q;
  assign status_o = status_q;
endmodule

// file: hw/core_cfg.svh
// constants for the harvard risc core datapath: widths, file map, status layout
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
`define INSTR_WIDTH 12
`define DATA_WIDTH 8
`define DADDR_WIDTH 7
`define PC_MAX_WIDTH 11
`define PC_WIDTH_DEFAULT 11
`define ADDR_INDIRECT 5'h00
`define ADDR_PCL 5'h02
`define ADDR_STATUS 5'h03
`define ADDR_FSR 5'h04
`define SFR_NONE 3'h0
`define SFR_INDIRECT 3'h1
`define SFR_PCL 3'h2
`define SFR_STATUS 3'h3
`define SFR_FSR 3'h4
`define STATUS_C_BIT 0
`define STATUS_DC_BIT 1
`define STATUS_Z_BIT 2
`define STATUS_PA_LO_BIT 5
`define STATUS_PA_HI_BIT 6
`define STATUS_RESET 8'h18
`define STATUS_WR_MASK 8'h67
`define FSR_RESET 8'h00
`define W_RESET 8'h00
`define NOP_WORD 12'h000
`endif

// file: hw/core_pkg.sv
// types shared by the core, its alu and its phase generator
package core_pkg;
  // four oscillator phases per instruction cycle, gray coded
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } phase_type;
  // alu operation select
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC,
    ALU_RRF, ALU_RLF, ALU_SWAP, ALU_PASS_F, ALU_PASS_W, ALU_CLR, ALU_BCF, ALU_BSF
  } alu_op_type;
endpackage

// file: hw/alu_unit.sv
// 8-bit alu: arithmetic, logic, shift and bit operations with flag outputs
`timescale 1ns/1ps
`include "core_cfg.svh"
module alu_unit (
  input wire core_pkg::alu_op_type op_i,
  input wire logic [`DATA_WIDTH-1:0] f_i,
  input wire logic [`DATA_WIDTH-1:0] w_i,
  input wire logic [2:0] bit_i,
  input wire logic carry_i,
  output logic [`DATA_WIDTH-1:0] result_o,
  output logic carry_o,
  output logic nibble_carry_o,
  output logic zero_o
);
  logic [8:0] sum; // full sum with carry out
  logic [4:0] low; // low nibble sum, bit 4 is the nibble carry

  // one adder path serves add and subtract; subtract is f + ~w + 1
  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    result_o = f_i;
    carry_o = carry_i;
    nibble_carry_o = 1'b0;
    case (op_i)
      core_pkg::ALU_ADD: begin
        sum = {1'b0, f_i} + {1'b0, w_i};
        low = {1'b0, f_i[3:0]} + {1'b0, w_i[3:0]};
        result_o = sum[7:0];
        carry_o = sum[8];
        nibble_carry_o = low[4];
      end
      core_pkg::ALU_SUB: begin
        // carry out of the complement add is the inverted borrow
        sum = {1'b0, f_i} + {1'b0, ~w_i} + 9'h001;
        low = {1'b0, f_i[3:0]} + {1'b0, ~w_i[3:0]} + 5'h01;
        result_o = sum[7:0];
        carry_o = sum[8];
        nibble_carry_o = low[4];
      end
      core_pkg::ALU_AND: result_o = f_i & w_i;
      core_pkg::ALU_IOR: result_o = f_i | w_i;
      core_pkg::ALU_XOR: result_o = f_i ^ w_i;
      core_pkg::ALU_COM: result_o = ~f_i;
      core_pkg::ALU_INC: result_o = f_i + 8'h01;
      core_pkg::ALU_DEC: result_o = f_i - 8'h01;
      core_pkg::ALU_RRF: begin
        result_o = {carry_i, f_i[7:1]};
        carry_o = f_i[0];
      end
      core_pkg::ALU_RLF: begin
        result_o = {f_i[6:0], carry_i};
        carry_o = f_i[7];
      end
      core_pkg::ALU_SWAP: result_o = {f_i[3:0], f_i[7:4]};
      core_pkg::ALU_PASS_W: result_o = w_i;
      core_pkg::ALU_CLR: result_o = 8'h00;
      core_pkg::ALU_BCF: result_o = f_i & ~(8'h01 << bit_i);
      core_pkg::ALU_BSF: result_o = f_i | (8'h01 << bit_i);
      default: result_o = f_i; // pass file operand
    endcase
    zero_o = (result_o == 8'h00);
  end
endmodule

// file: hw/quarter_phase_gen.sv
// divides the oscillator clock into four instruction phases and the rate output
`timescale 1ns/1ps
module quarter_phase_gen (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic hold_i,
  input wire logic rc_mode_i,
  output core_pkg::phase_type phase_o,
  output logic cycle_end_o,
  output logic rate_clk_o
);
  core_pkg::phase_type phase_q; // current phase
  core_pkg::phase_type phase_d;
  logic rate_q; // rate output register
  logic rate_d;

  // next phase and next rate level; held at the first phase during reset
  always_comb begin
    phase_d = core_pkg::PH_Q1;
    if (!hold_i) begin
      case (phase_q)
        core_pkg::PH_Q1: phase_d = core_pkg::PH_Q2;
        core_pkg::PH_Q2: phase_d = core_pkg::PH_Q3;
        core_pkg::PH_Q3: phase_d = core_pkg::PH_Q4;
        default: phase_d = core_pkg::PH_Q1;
      endcase
    end
    // high in the second half of each cycle: a quarter of the input rate
    rate_d = rc_mode_i && !hold_i &&
      (phase_d == core_pkg::PH_Q3 || phase_d == core_pkg::PH_Q4);
  end

  // registers only
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_q <= core_pkg::PH_Q1;
      rate_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      rate_q <= rate_d;
    end
  end

  assign phase_o = phase_q;
  assign cycle_end_o = (phase_q == core_pkg::PH_Q4) && !hold_i;
  assign rate_clk_o = rate_q;
endmodule

// file: dv/harvard_risc_core_datapath_monitor.sv
// concurrent checks on the core datapath ports, bound into the design
`timescale 1ns/1ps
`include "core_cfg.svh"
module harvard_risc_core_datapath_monitor #(
  parameter int PC_WIDTH = `PC_WIDTH_DEFAULT
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic master_reset_n_i,
  input wire logic rc_mode_i,
  input wire logic [PC_WIDTH-1:0] prog_addr_o,
  input wire logic [`DADDR_WIDTH-1:0] data_addr_o,
  input wire logic data_we_o,
  input wire logic instruction_rate_output_o,
  input wire logic [`DATA_WIDTH-1:0] acc_o,
  input wire logic [`DATA_WIDTH-1:0] status_o
);
  // one domain, so one clocking and one disable for all checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // write strobe is a single clock pulse
  property p_we_pulse; data_we_o |=> !data_we_o; endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe longer than one clock");
  // special registers are answered inside, never on the data bus
  property p_we_sfr;
    data_we_o |-> !(data_addr_o[4:0] inside {`ADDR_INDIRECT, `ADDR_PCL, `ADDR_STATUS, `ADDR_FSR});
  endproperty
  a_we_sfr: assert property (p_we_sfr)
    else $error("special register written on data bus");
  // a data write follows the commit edge of its own cycle
  property p_we_commit;
    $rose(data_we_o) |-> $changed(prog_addr_o) || ($past(prog_addr_o) != $past(prog_addr_o, 2));
  endproperty
  a_we_commit: assert property (p_we_commit) else $error("write outside commit");
  // the fetch address stands a whole four clock cycle unless reset intervenes
  property p_pc_stands;
    $changed(prog_addr_o) ##[1:3] $changed(prog_addr_o) |-> !master_reset_n_i;
  endproperty
  a_pc_stands: assert property (p_pc_stands)
    else $error("fetch address held under 4 clocks");
  // pin reset holds the core at its reset state
  property p_mreset;
    (!master_reset_n_i)[*5] |-> prog_addr_o == '1 && acc_o == `W_RESET &&
      status_o == `STATUS_RESET && !data_we_o && !instruction_rate_output_o;
  endproperty
  a_mreset: assert property (p_mreset) else $error("core not held by pin reset");
  // accumulator only moves at an instruction commit
  property p_acc_commit; $changed(acc_o) |-> $changed(prog_addr_o); endproperty
  a_acc_commit: assert property (p_acc_commit)
    else $error("accumulator moved mid cycle");
  // flags only move at an instruction commit
  property p_flags_commit; $changed(status_o[2:0]) |-> $changed(prog_addr_o); endproperty
  a_flags_commit: assert property (p_flags_commit) else $error("flags moved mid cycle");
  // rate output stays low outside rc mode
  property p_rate_off; (!rc_mode_i)[*5] |-> !instruction_rate_output_o; endproperty
  a_rate_off: assert property (p_rate_off)
    else $error("rate output active outside rc mode");
  // two clocks high, two low: one quarter of the oscillator
  property p_rate_period;
    (rc_mode_i && master_reset_n_i)[*6] ##0 $rose(instruction_rate_output_o) |->
      (instruction_rate_output_o[*2] ##1 (!instruction_rate_output_o)[*2] ##1
      instruction_rate_output_o) or (##[0:6] !rc_mode_i);
  endproperty
  a_rate_period: assert property (p_rate_period)
    else $error("rate output not quarter rate");
  // a new cycle opens with the rate output low
  property p_rate_q1;
    (rc_mode_i && master_reset_n_i)[*6] ##0 $changed(prog_addr_o) |-> !instruction_rate_output_o;
  endproperty
  a_rate_q1: assert property (p_rate_q1)
    else $error("rate output high at cycle start");
endmodule
bind harvard_risc_core_datapath harvard_risc_core_datapath_monitor #(.PC_WIDTH(PC_WIDTH)) u_mon (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .master_reset_n_i(master_reset_n_i),
  .rc_mode_i(rc_mode_i), .prog_addr_o(prog_addr_o), .data_addr_o(data_addr_o),
  .data_we_o(data_we_o), .instruction_rate_output_o(instruction_rate_output_o),
  .acc_o(acc_o), .status_o(status_o)
);

// file: dv/core_memory_model.sv
// program memory and data file model facing the core
`timescale 1ns/1ps
`include "core_cfg.svh"
module core_memory_model #(
  parameter int PC_WIDTH = 9
) (
  input wire logic clock_i,
  input wire logic [PC_WIDTH-1:0] prog_addr_i,
  output logic [`INSTR_WIDTH-1:0] prog_data_o,
  input wire logic [`DADDR_WIDTH-1:0] data_addr_i,
  input wire logic [`DATA_WIDTH-1:0] data_wdata_i,
  input wire logic data_we_i,
  output logic [`DATA_WIDTH-1:0] data_rdata_o,
  output int writes_o
);
  logic [`INSTR_WIDTH-1:0] rom [16]; // test program; all else, reset vector too, is nop
  logic [`DATA_WIDTH-1:0] ram [128]; // data file behind its own bus
  initial begin
    rom = '{12'hC0F, 12'h030, 12'h024, 12'hC01, 12'h1D0, 12'hC01, 12'h090, 12'hC10,
            12'h090, 12'hC0F, 12'h090, 12'hCF2, 12'h1D0, 12'hF01, 12'hA0E, 12'hC55};
    for (int i = 0; i < 128; i++) ram[i] = 8'h00;
    writes_o = 0;
  end
  // whole 12-bit word from the fetch address alone
  assign prog_data_o = (prog_addr_i[PC_WIDTH-1:4] == '0) ?
    rom[prog_addr_i[3:0]] : 12'h000;
  // data read on a separate bus, valid in the same cycle as a fetch
  assign data_rdata_o = ram[data_addr_i];
  // writes land on the strobe clock and are counted
  always @(posedge clock_i) begin
    if (data_we_i === 1'b1) begin
      ram[data_addr_i] <= data_wdata_i;
      writes_o <= writes_o + 1;
    end
  end
endmodule

// file: dv/tb_harvard_risc_core_datapath.sv
// self-checking bench for the core datapath and its memory model
`timescale 1ns/1ps
`include "core_cfg.svh"
module tb_harvard_risc_core_datapath;
  localparam int PW = 9; // smallest variant, 512 words
  logic clock_i, sys_rst_i, master_reset_n, rc_mode, we, rate;
  logic [PW-1:0] pc;
  logic [`INSTR_WIDTH-1:0] instr;
  logic [`DADDR_WIDTH-1:0] daddr;
  logic [`DATA_WIDTH-1:0] wdata, rdata, acc, status;
  int writes, errors, n_checks;
  harvard_risc_core_datapath #(.PC_WIDTH(PW)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .master_reset_n_i(master_reset_n),
    .rc_mode_i(rc_mode), .prog_addr_o(pc), .prog_data_i(instr), .data_addr_o(daddr),
    .data_wdata_o(wdata), .data_we_o(we), .data_rdata_i(rdata),
    .instruction_rate_output_o(rate), .acc_o(acc), .status_o(status));
  core_memory_model #(.PC_WIDTH(PW)) mem (
    .clock_i(clock_i), .prog_addr_i(pc), .prog_data_o(instr), .data_addr_i(daddr),
    .data_wdata_i(wdata), .data_we_i(we), .data_rdata_o(rdata), .writes_o(writes));
  // free running oscillator, 100 ns period
  initial begin
    clock_i = 0;
    forever #50 clock_i = ~clock_i;
  end
  // step past edges, always landing 1 ns after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for a fetch address; stands 4 clocks so polling each clock catches it
  task automatic wait_pc(input logic [15:0] target);
    for (int i = 0; i < 40 && {7'h00, pc} !== target; i++) tick(1);
    check("fetch address", target, {7'h00, pc});
  endtask
  task automatic t_reset;
    check("acc", 16'h0000, {8'h00, acc});
    check("status", 16'h0018, {8'h00, status});
    check("fetch address", 16'h01FF, {7'h00, pc});
  endtask
  // result of the word at k is seen once the fetch address reaches k+2
  task automatic t_alu;
    logic [15:0] tbl [6][3];
    tbl = '{'{16'h0006, 16'h0010, 16'h001A}, '{16'h0008, 16'h000E, 16'h001B},
            '{16'h000A, 16'h00FF, 16'h001A}, '{16'h000C, 16'h0000, 16'h001F},
            '{16'h000E, 16'h0001, 16'h001B}, '{16'h000F, 16'h0000, 16'h001F}};
    for (int i = 0; i < 6; i++) begin
      wait_pc(tbl[i][0]);
      check("acc", tbl[i][1], {8'h00, acc});
      check("status", tbl[i][2], {8'h00, status});
    end
  endtask
  // only the file store reaches the bus; the pointer store stays inside
  task automatic t_writes;
    check("write count", 16'h0001, 16'(writes));
    check("file 0x10", 16'h000F, {8'h00, mem.ram[16]});
  endtask
  // the self jump must flush the word behind it
  task automatic t_branch;
    logic [PW-1:0] hi;
    hi = '0;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (pc > hi) hi = pc;
    end
    check("highest fetch", 16'h000F, {7'h00, hi});
    check("acc", 16'h0000, {8'h00, acc});
  endtask
  task automatic t_rate;
    int rises;
    logic prev;
    rises = 0;
    prev = rate;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (rate === 1'b1 && prev === 1'b0) rises++;
      prev = rate;
    end
    check("rate rises", 16'h000A, 16'(rises));
    rc_mode = 1'b0;
    tick(6);
    rises = 0;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (rate !== 1'b0) rises++;
    end
    check("rate high clocks", 16'h0000, 16'(rises));
  endtask
  // pin reset held long, then the program must run again from the vector
  task automatic t_mreset;
    master_reset_n = 1'b0;
    tick(6);
    t_reset();
    tick(20);
    check("fetch address", 16'h01FF, {7'h00, pc});
    master_reset_n = 1'b1;
    wait_pc(16'h0006);
    check("acc", 16'h0010, {8'h00, acc});
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence: reset held for two clocks, then each scenario in turn
  initial begin
    errors = 0;
    n_checks = 0;
    sys_rst_i = 1'b1;
    master_reset_n = 1'b1;
    rc_mode = 1'b1;
    tick(2);
    sys_rst_i = 1'b0;
    tick(1);
    t_reset();
    t_alu();
    t_writes();
    t_branch();
    t_rate();
    t_mreset();
    wrap_up();
  end
  // whole run needs well under 400 clocks; cut a hang at 2000
  initial begin
    #(2000 * 100);
    errors++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule
